// ### fdrc_top.sv
// DDR read command logic of a serial flash: decode, address, stream
// Operation
// - Single line: one bit per clock edge
// - Any start address, increment per byte out
// - Past highest address wrap to zero
// - 0Dh uses address flag, 0Eh four bytes
// - Opcode, DDR address, dummy, DDR data out
// - Chip enable high ends read, stops output
// - Single line read rejected while writing
// - Quad opcode mode: opcode in two clocks
// - Quad opcode mode: four lines, six dummies default
// - No continuous read in quad opcode mode
// - Quad opcode read rejected while writing
// - Dual line: two bits per clock edge
// - BDh uses address flag, BEh four bytes
// - Dual: opcode serial, four dummy clocks default
// - Mode nibble A enters continuous read
// - Other mode nibble leaves continuous read
// - Dual line read rejected while writing
// - Dummy count follows read parameter setting
// - Write in progress shows running operation
`timescale 1ns/1ps
module fdrc_top
  import fdrc_pkg::*;
#(
  parameter int ADDR_WIDTH = 24,
  parameter int BUF_DEPTH  = 2
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // Flash pins, asynchronous to clk
  input  wire logic                  chipEnableN,
  input  wire logic                  serialClock,
  input  wire logic [3:0]            ioIn,
  output logic      [3:0]            ioOut,
  output logic      [3:0]            ioOe,
  // Configuration
  input  wire logic                  four_byte_address_flag,
  input  wire logic                  quad_opcode_mode,
  input  wire logic [3:0]            dummySingle,
  input  wire logic [3:0]            dummyQuad,
  input  wire logic [3:0]            dummyDual,
  // Internal operations that make the device busy
  input  wire logic                  programActive,
  input  wire logic                  eraseActive,
  input  wire logic                  statusWriteActive,
  // Status
  output logic                       write_in_progress,
  output logic                       continuous_read_mode,
  output logic                       readActive,
  output logic                       commandRejected,
  // Array read port
  output logic                       memReqValid,
  input  wire logic                  memReqReady,
  output logic      [ADDR_WIDTH-1:0] memReqAddr,
  input  wire logic                  memRspValid,
  output logic                       memRspReady,
  input  wire logic [7:0]            memRspData
);

  fdrc_state_type state_q;
  fdrc_lane_type  lane_q;
  logic [1:0]            ceSync_q;
  logic [1:0]            sckSync_q;
  logic [3:0]            ioSync1_q;
  logic [3:0]            ioSync2_q;
  logic                  sckPrev_q;
  logic [6:0]            cnt_q;
  logic [31:0]           shiftIn_q;
  logic [7:0]            shiftOut_q;
  logic [6:0]            addrBits_q;
  logic [3:0]            dummy_q;
  logic                  dual_q;
  logic [3:0]            modeNibble_q;
  logic                  contMode_q;
  logic                  contAddr4_q;
  logic [ADDR_WIDTH-1:0] fetchAddr_q;
  logic [1:0]            credit_q;
  logic                  wip_q;
  logic                  reject_q;
  logic [3:0]            ioOut_q;
  logic [3:0]            ioOe_q;

  logic        ceHigh;
  logic        sckRise;
  logic        sckEdge;
  logic [31:0] shiftNext;
  logic [7:0]  opcodeNext;
  logic        bufValid;
  logic [7:0]  bufData;
  logic        bufPop;
  logic        bufPush;
  logic        flush;
  logic        byteDone;
  logic        dummyDone;
  logic        addrDone;
  logic        reqFire;

  function automatic logic [6:0] bitsPerEdge(input fdrc_lane_type l);
    case (l)
      LANE2:   bitsPerEdge = 7'h02;
      LANE4:   bitsPerEdge = 7'h04;
      default: bitsPerEdge = 7'h01;
    endcase
  endfunction

  // Shift sampled lanes in, first bit received lands highest
  function automatic logic [31:0] shiftLanes(input logic [31:0] sh,
                                             input logic [3:0] io,
                                             input fdrc_lane_type l);
    case (l)
      LANE2:   shiftLanes = {sh[29:0], io[1:0]};
      LANE4:   shiftLanes = {sh[27:0], io};
      default: shiftLanes = {sh[30:0], io[0]};
    endcase
  endfunction

  // Serial output leaves on IO1; dual uses IO0 and IO1, quad all four lines
  function automatic logic [3:0] laneDrive(input logic [7:0] b,
                                           input fdrc_lane_type l);
    case (l)
      LANE2:   laneDrive = {2'b00, b[7:6]};
      LANE4:   laneDrive = b[7:4];
      default: laneDrive = {2'b00, b[7], 1'b0};
    endcase
  endfunction

  function automatic logic [3:0] laneEnable(input fdrc_lane_type l);
    case (l)
      LANE2:   laneEnable = 4'h3;
      LANE4:   laneEnable = 4'hf;
      default: laneEnable = 4'h2;
    endcase
  endfunction

  function automatic logic [3:0] pickDummy(input logic [3:0] cfg,
                                           input logic [3:0] def);
    pickDummy = (cfg == 4'h0) ? def : cfg;
  endfunction

  function automatic logic [ADDR_WIDTH-1:0] incAddr(
    input logic [ADDR_WIDTH-1:0] a);
    incAddr = (a == '1) ? '0 : a + ADDR_WIDTH'(1);
  endfunction

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ceSync_q  <= 2'b11;
      sckSync_q <= 2'b00;
      ioSync1_q <= 4'h0;
      ioSync2_q <= 4'h0;
      sckPrev_q <= 1'b0;
    end
    else
    begin
      ceSync_q  <= {ceSync_q[0], chipEnableN};
      sckSync_q <= {sckSync_q[0], serialClock};
      ioSync1_q <= ioIn;
      ioSync2_q <= ioSync1_q;
      sckPrev_q <= sckSync_q[1];
    end
  end

  assign ceHigh     = ceSync_q[1];
  assign sckRise    = sckSync_q[1] & ~sckPrev_q;
  assign sckEdge    = sckSync_q[1] ^ sckPrev_q;
  assign shiftNext  = shiftLanes(shiftIn_q, ioSync2_q, lane_q);
  assign opcodeNext = quad_opcode_mode ? {shiftIn_q[3:0], ioSync2_q}
                                       : {shiftIn_q[6:0], ioSync2_q[0]};
  assign addrDone   = (state_q == ST_ADDR) && sckEdge &&
                      (cnt_q == addrBits_q / bitsPerEdge(lane_q)
                                - 7'h01);
  assign dummyDone  = (state_q == ST_DUMMY) && sckEdge &&
                      (cnt_q == {2'b00, dummy_q, 1'b0} - 7'h01);
  assign byteDone   = (state_q == ST_DATA) && sckEdge &&
                      (cnt_q == 7'h08 / bitsPerEdge(lane_q) - 7'h01);
  assign bufPop     = (dummyDone || byteDone) && bufValid;
  assign flush      = ceHigh;

  // Busy flag: any program, erase or status write
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wip_q <= 1'b0;
    else
      wip_q <= programActive | eraseActive | statusWriteActive;
  end

  // Command sequencer
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q     <= ST_IDLE;
      lane_q      <= LANE1;
      cnt_q       <= 7'h00;
      shiftIn_q   <= 32'h0;
      addrBits_q  <= ADDR_BITS_3B;
      dummy_q     <= DUMMY_SINGLE_DEF;
      dual_q      <= 1'b0;
      reject_q    <= 1'b0;
    end
    else
    begin
      reject_q <= 1'b0;
      if (ceHigh)
      begin
        state_q   <= ST_IDLE;
        cnt_q     <= 7'h00;
        shiftIn_q <= 32'h0;
      end
      else
      begin
        case (state_q)
          ST_IDLE:
          begin
            cnt_q <= 7'h00;
            // Continuous read skips the opcode, address comes first
            if (contMode_q && wip_q)
            begin
              state_q  <= ST_IGNORE;
              reject_q <= 1'b1;
            end
            else if (contMode_q)
            begin
              state_q    <= ST_ADDR;
              lane_q     <= LANE2;
              dual_q     <= 1'b1;
              addrBits_q <= contAddr4_q ? ADDR_BITS_4B : ADDR_BITS_3B;
              dummy_q    <= pickDummy(dummyDual, DUMMY_DUAL_DEF);
            end
            else
            begin
              state_q <= ST_OPCODE;
              lane_q  <= quad_opcode_mode ? LANE4 : LANE1;
            end
          end
          ST_OPCODE:
          begin
            if (sckRise)
            begin
              shiftIn_q <= {24'h0, opcodeNext};
              cnt_q     <= cnt_q + 7'h01;
              if (cnt_q == (quad_opcode_mode ? OPCODE_CLOCKS_QUAD
                                             : OPCODE_CLOCKS_SERIAL)
                           - 7'h01)
              begin
                cnt_q     <= 7'h00;
                shiftIn_q <= 32'h0;
                state_q   <= ST_ADDR;
                addrBits_q <= (four_byte_address_flag ||
                               opcodeNext == OP_SINGLE_DDR_4B ||
                               opcodeNext == OP_DUAL_DDR_4B)
                              ? ADDR_BITS_4B : ADDR_BITS_3B;
                dual_q <= 1'b0;
                if (opcodeNext == OP_SINGLE_DDR ||
                    opcodeNext == OP_SINGLE_DDR_4B)
                begin
                  // Quad opcode mode keeps four lines for everything
                  lane_q  <= quad_opcode_mode ? LANE4 : LANE1;
                  dummy_q <= quad_opcode_mode
                             ? pickDummy(dummyQuad, DUMMY_QUAD_DEF)
                             : pickDummy(dummySingle, DUMMY_SINGLE_DEF);
                end
                else if (!quad_opcode_mode &&
                         (opcodeNext == OP_DUAL_DDR ||
                          opcodeNext == OP_DUAL_DDR_4B))
                begin
                  lane_q  <= LANE2;
                  dual_q  <= 1'b1;
                  dummy_q <= pickDummy(dummyDual, DUMMY_DUAL_DEF);
                end
                else
                  state_q <= ST_IGNORE;
                if (wip_q)
                begin
                  // Read refused; the write cycle is left untouched
                  state_q  <= ST_IGNORE;
                  reject_q <= 1'b1;
                end
              end
            end
          end
          ST_ADDR:
          begin
            // Address opens on a rise; the fall closing the opcode is idle
            if (sckRise || (sckEdge && cnt_q != 7'h00))
            begin
              shiftIn_q <= shiftNext;
              cnt_q     <= cnt_q + 7'h01;
              if (addrDone)
              begin
                cnt_q   <= 7'h00;
                state_q <= ST_DUMMY;
              end
            end
          end
          ST_DUMMY:
          begin
            if (sckEdge)
            begin
              cnt_q <= cnt_q + 7'h01;
              if (dummyDone)
              begin
                cnt_q   <= 7'h00;
                state_q <= ST_DATA;
              end
            end
          end
          ST_DATA:
          begin
            if (sckEdge)
            begin
              cnt_q <= byteDone ? 7'h00 : cnt_q + 7'h01;
            end
          end
          ST_IGNORE:
            cnt_q <= 7'h00;
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Mode byte and continuous read flag
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      modeNibble_q <= 4'h0;
      contMode_q   <= 1'b0;
      contAddr4_q  <= 1'b0;
    end
    else
    begin
      // Upper nibble arrives on the first two dummy edges
      if (!ceHigh && state_q == ST_DUMMY && sckEdge && dual_q &&
          cnt_q < MODE_EDGES_DUAL)
        modeNibble_q <= {modeNibble_q[1:0], ioSync2_q[1:0]};
      if (!ceHigh && dummyDone)
      begin
        // Only the dual line read may stay in continuous read
        contMode_q  <= dual_q && (modeNibble_q == CONT_MODE_NIBBLE);
        contAddr4_q <= (addrBits_q == ADDR_BITS_4B);
      end
    end
  end

  // Fetch address and credit; bytes are prefetched in address order
  assign memReqValid = (state_q == ST_DUMMY || state_q == ST_DATA) &&
                       !ceHigh && (credit_q < 2'(BUF_DEPTH));
  assign memReqAddr  = fetchAddr_q;
  assign reqFire     = memReqValid & memReqReady;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fetchAddr_q <= '0;
      credit_q    <= 2'b00;
    end
    else
    begin
      if (ceHigh)
        credit_q <= 2'b00;
      else
        credit_q <= credit_q + 2'(reqFire) - 2'(bufPop);
      if (addrDone)
        fetchAddr_q <= shiftNext[ADDR_WIDTH-1:0];
      else if (reqFire)
        fetchAddr_q <= incAddr(fetchAddr_q);
    end
  end

  // Output shifter; lines change on each clock edge of the data phase
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shiftOut_q <= 8'h00;
      ioOut_q    <= 4'h0;
      ioOe_q     <= 4'h0;
    end
    else if (ceHigh)
    begin
      ioOut_q <= 4'h0;
      ioOe_q  <= 4'h0;
    end
    else if (dummyDone || byteDone)
    begin
      // Late array data would stall nothing; the lines show a filler
      shiftOut_q <= bufValid ? bufData : UNDERRUN_BYTE;
      ioOut_q    <= laneDrive(bufValid ? bufData : UNDERRUN_BYTE,
                              lane_q);
      ioOe_q     <= laneEnable(lane_q);
    end
    else if (state_q == ST_DATA && sckEdge)
    begin
      shiftOut_q <= shiftOut_q << bitsPerEdge(lane_q);
      ioOut_q    <= laneDrive(shiftOut_q << bitsPerEdge(lane_q), lane_q);
    end
  end

  // Responses arriving outside a read are dropped
  assign bufPush = memRspValid &&
                   (state_q == ST_DUMMY || state_q == ST_DATA);

  fdrc_buf2 #(
    .WIDTH (8),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk      (clk),
    .resetn   (resetn),
    .flush    (flush),
    .inValid  (bufPush),
    .inReady  (memRspReady),
    .inData   (memRspData),
    .outValid (bufValid),
    .outReady (bufPop),
    .outData  (bufData)
  );

  assign ioOut                = ioOut_q;
  assign ioOe                 = ioOe_q;
  assign write_in_progress    = wip_q;
  assign continuous_read_mode = contMode_q;
  assign readActive           = (state_q == ST_DATA);
  assign commandRejected      = reject_q;

endmodule

// ### fdrc_pkg.sv
// Constants and types shared by the DDR read command logic
package fdrc_pkg;

  // Command codes
  localparam logic [7:0] OP_SINGLE_DDR    = 8'h0d;
  localparam logic [7:0] OP_SINGLE_DDR_4B = 8'h0e;
  localparam logic [7:0] OP_DUAL_DDR      = 8'hbd;
  localparam logic [7:0] OP_DUAL_DDR_4B   = 8'hbe;

  // Upper nibble of the mode byte that keeps continuous read
  localparam logic [3:0] CONT_MODE_NIBBLE = 4'ha;

  // Default dummy clocks, used when the configured count is zero
  localparam logic [3:0] DUMMY_SINGLE_DEF = 4'h8;
  localparam logic [3:0] DUMMY_QUAD_DEF   = 4'h6;
  localparam logic [3:0] DUMMY_DUAL_DEF   = 4'h4;

  // Opcode length in serial clocks
  localparam logic [6:0] OPCODE_CLOCKS_SERIAL = 7'h08;
  localparam logic [6:0] OPCODE_CLOCKS_QUAD   = 7'h02;

  // Address lengths in bits
  localparam logic [6:0] ADDR_BITS_3B = 7'h18;
  localparam logic [6:0] ADDR_BITS_4B = 7'h20;

  // Edges taken by the upper mode nibble on the dual lines
  localparam logic [6:0] MODE_EDGES_DUAL = 7'h02;

  // Byte shown on the lines when the array has not answered in time
  localparam logic [7:0] UNDERRUN_BYTE = 8'hff;

  typedef enum logic [1:0] {LANE1, LANE2, LANE4} fdrc_lane_type;

  typedef enum {
    ST_IDLE,
    ST_OPCODE,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } fdrc_state_type;

endpackage

// ### fdrc_buf2.sv
// Small flushable FIFO between array reads and the output shifter
`timescale 1ns/1ps
module fdrc_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             flush,
  // Filling side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Draining side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] store_q [DEPTH];
  logic [PW-1:0]    wrPtr_q;
  logic [PW-1:0]    rdPtr_q;
  logic [PW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != (PW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = store_q[rdPtr_q];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
    nextPtr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else if (flush)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wrPtr_q <= nextPtr(wrPtr_q);
      if (pop)
        rdPtr_q <= nextPtr(rdPtr_q);
      if (push && !pop)
        count_q <= count_q + (PW+1)'(1);
      else if (pop && !push)
        count_q <= count_q - (PW+1)'(1);
    end
  end

  // Storage needs no reset; empty entries are never read out
  always_ff @(posedge clk)
  begin
    if (push)
      store_q[wrPtr_q] <= inData;
  end

endmodule

// ### fdrc_asserts.sv
// Port-level checks for the DDR read command logic
`timescale 1ns/1ps
module fdrc_asserts #(
  parameter int ADDR_WIDTH = 24
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  resetn,
  // Pins and configuration
  input wire logic                  chipEnableN,
  input wire logic [3:0]            ioOe,
  input wire logic                  quad_opcode_mode,
  // Busy sources and status
  input wire logic                  programActive,
  input wire logic                  eraseActive,
  input wire logic                  statusWriteActive,
  input wire logic                  write_in_progress,
  input wire logic                  continuous_read_mode,
  input wire logic                  readActive,
  input wire logic                  commandRejected,
  // Array request side
  input wire logic                  memReqValid,
  input wire logic                  memReqReady,
  input wire logic [ADDR_WIDTH-1:0] memReqAddr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_oe_release:
    assert property (chipEnableN [*6] |-> ioOe == 4'h0)
    else $error("lines still driven after deselect");
  chk_reject_pulse:
    assert property (commandRejected |-> write_in_progress ##1 !commandRejected)
    else $error("refusal pulse wrong");
  chk_reject_quiet:
    assert property (commandRejected |-> ioOe == 4'h0 && !readActive)
    else $error("refused read still drives");
  chk_busy_noread:
    assert property ($rose(readActive) |-> !write_in_progress)
    else $error("read started while busy");
  chk_wip_track:
    assert property (write_in_progress ==
      $past(programActive || eraseActive || statusWriteActive))
    else $error("busy flag does not follow sources");
  chk_lane_set:
    assert property (ioOe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal output enable set");
  chk_quad_nocont:
    assert property ($rose(continuous_read_mode) |-> !quad_opcode_mode)
    else $error("continuous mode in quad opcode mode");
  chk_req_hold:
    assert property ((!chipEnableN [*4] ##0 memReqValid && !memReqReady)
      |=> memReqValid && $stable(memReqAddr))
    else $error("array request dropped before accept");
endmodule

// ### fdrc_host_model.sv
// Host-side model of the flash controller facing the pins
`timescale 1ns/1ps
module fdrc_host_model (
  // System clock
  input  wire logic       clk,
  // Flash pins
  output logic            ceN,
  output logic            sck,
  output logic      [3:0] io,
  input  wire logic [3:0] ioOut,
  // Bytes taken from the data phase
  output logic            gotByte,
  output logic      [7:0] gotData
);
  logic [3:0] smp;

  initial
  begin
    ceN = 1'b1;
    sck = 1'b0;
    io = 4'h0;
    gotByte = 1'b0;
    gotData = 8'h00;
  end

  function automatic logic [3:0] top(logic [31:0] x, int n);
    return 4'(x >> (32 - n));
  endfunction

  // 20 clk per edge: 160 ns link period; sample just before toggling
  task automatic tick(logic [3:0] v);
    io <= v;
    repeat (10) @(posedge clk);
    smp = ioOut;
    sck <= ~sck;
    repeat (10) @(posedge clk);
  endtask

  task automatic xfer(logic [7:0] op, int ln, bit qo, bit sk, int ab,
                      logic [31:0] ad, int dm, logic [3:0] md, int n);
    logic [31:0] sh;
    logic [7:0]  b;
    logic [3:0]  m;
    m = ln == 1 ? 4'h2 : 4'((1 << ln) - 1);
    ceN <= 1'b0;
    repeat (6) @(posedge clk);
    sh = {op, 24'h0};
    // Opcode held over both edges, taken on the rising one
    for (int i = 0; i < (sk ? 0 : qo ? 2 : 8); i++)
    begin
      tick(top(sh, qo ? 4 : 1));
      tick(top(sh, qo ? 4 : 1));
      sh = sh << (qo ? 4 : 1);
    end
    sh = ad << (32 - 8 * ab);
    for (int i = 0; i < 8 * ab / ln; i++)
    begin
      tick(top(sh, ln));
      sh = sh << ln;
    end
    // Mode byte AX: quad repeats A as X, dual floats X as noise
    sh = {md, md, 24'h0};
    for (int i = 0; i < 2 * dm; i++)
    begin
      tick(i * ln < (ln == 4 ? 8 : 4) ? top(sh, ln) : 4'($urandom));
      sh = sh << ln;
    end
    for (int k = 0; k < n; k++)
    begin
      b = 8'h00;
      for (int j = 0; j < 8 / ln; j++)
      begin
        tick(4'($urandom));
        b = (b << ln) | 8'((smp & m) >> (ln == 1));
      end
      gotData <= b;
      gotByte <= 1'b1;
      @(posedge clk);
      gotByte <= 1'b0;
    end
    repeat (6) @(posedge clk);
    ceN <= 1'b1;
    repeat (12) @(posedge clk);
  endtask
endmodule

// ### testbench.sv
// Self-checking bench for the DDR read command logic
`timescale 1ns/1ps
module testbench;
  import fdrc_pkg::*;
  localparam int AW = 24;
  logic          clk = 1'b0;
  logic          resetn = 1'b0;
  logic          ceN, sck, gotByte, cont, rdAct, rej, reqV, rspR;
  logic          quadOp = 1'b0, fourB = 1'b0, reqR = 1'b0, rspV = 1'b0;
  logic [3:0]    io, ioOut, ioOe, ioLine;
  logic [3:0]    dS = 4'h0, dQ = 4'h0, dD = 4'h0;
  logic [2:0]    busy = 3'h0;
  logic          busyFlag;
  logic [7:0]    gotData, rspData = 8'h00;
  logic [AW-1:0] reqA;
  logic [AW-1:0] pend[$];
  logic [7:0]    expQ[$];
  int            err_total = 0, check_count = 0, cycles = 0, rejN, oeHit, d;

  always #2 clk = ~clk;
  // Wire level: device wins where it drives
  assign ioLine = (ioOe & ioOut) | (~ioOe & io);

  fdrc_host_model host (.clk(clk), .ceN(ceN), .sck(sck), .io(io),
    .ioOut(ioOut), .gotByte(gotByte), .gotData(gotData));

  fdrc_top #(.ADDR_WIDTH(AW)) u_dut (.clk(clk), .resetn(resetn),
    .chipEnableN(ceN), .serialClock(sck), .ioIn(ioLine), .ioOut(ioOut),
    .ioOe(ioOe), .four_byte_address_flag(fourB),
    .quad_opcode_mode(quadOp), .dummySingle(dS), .dummyQuad(dQ),
    .dummyDual(dD), .programActive(busy[0]), .eraseActive(busy[1]),
    .statusWriteActive(busy[2]), .write_in_progress(busyFlag),
    .continuous_read_mode(cont), .readActive(rdAct),
    .commandRejected(rej), .memReqValid(reqV), .memReqReady(reqR),
    .memReqAddr(reqA), .memRspValid(rspV), .memRspReady(rspR),
    .memRspData(rspData));

  function automatic logic [7:0] memByte(logic [AW-1:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  // Array model with random stalls; a deselect flushes it
  always @(posedge clk)
  begin
    reqR <= ($urandom % 4) != 0;
    if (ceN)
    begin
      pend.delete();
      rspV <= 1'b0;
    end
    else
    begin
      if (reqV && reqR)
        pend.push_back(reqA);
      if (rspV && rspR)
        rspV <= 1'b0;
      else if (!rspV && pend.size() > 0 && $urandom % 2)
      begin
        rspData <= memByte(pend.pop_front());
        rspV <= 1'b1;
      end
    end
  end

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (e !== g)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (rej === 1'b1)
      rejN++;
    if (ioOe !== 4'h0 || rdAct !== 1'b0)
      oeHit = 1;
    if (gotByte === 1'b1)
      chk("read byte", expQ.size() ? expQ.pop_front() : 9'h100,
          gotData);
    if (cycles == 60000)
    begin
      err_total++;
      wrap_up();
    end
  end

  task automatic cfg(bit q, bit f, logic [3:0] s, qd, dd);
    @(posedge clk);
    quadOp <= q;
    fourB <= f;
    dS <= s;
    dQ <= qd;
    dD <= dd;
    @(posedge clk);
  endtask

  // dm is the dummy count in effect, worked out by the caller
  task automatic run(string nm, logic [7:0] op, int ln, bit sk, int ab,
                     logic [31:0] ad, int dm, logic [3:0] md, int n);
    logic [AW-1:0] a;
    a = ad[AW-1:0];
    repeat (n)
    begin
      expQ.push_back(memByte(a));
      a++;
    end
    host.xfer(op, ln, quadOp, sk, ab, ad, dm, md, n);
    repeat (8) @(posedge clk);
    chk("lines released", 4'h0, ioOe);
    chk("bytes left", 0, expQ.size());
    $display("Test %s done", nm);
  endtask

  initial
  begin
    void'($urandom(97));
    repeat (4) @(posedge clk);
    chk("oe in reset", 4'h0, ioOe);
    chk("ready in reset", 1'b1, rspR);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    run("serial", OP_SINGLE_DDR, 1, 0, 3, $urandom, 8, 4'h0, 3);
    cfg(0, 1, 4'h5, 4'h0, 4'h0);
    run("wrap", OP_SINGLE_DDR, 1, 0, 4, 32'h80fffffe, 5, 4'h0, 4);
    cfg(0, 0, 4'h5, 4'h0, 4'h0);
    run("serial4", OP_SINGLE_DDR_4B, 1, 0, 4, $urandom, 5, 4'h0, 2);
    cfg(1, 0, 4'h0, 4'h0, 4'h0);
    run("quad", OP_SINGLE_DDR, 4, 0, 3, $urandom, 6, 4'ha, 4);
    chk("quad no cont", 1'b0, cont);
    cfg(1, 0, 4'h0, 4'h3, 4'h0);
    run("quad4", OP_SINGLE_DDR_4B, 4, 0, 4, $urandom, 3, 4'h0, 3);
    cfg(0, 0, 4'h0, 4'h0, 4'h0);
    run("dual", OP_DUAL_DDR, 2, 0, 3, $urandom, 4, 4'ha, 3);
    chk("cont set", 1'b1, cont);
    run("dual cont", 8'h00, 2, 1, 3, $urandom, 4, 4'h5, 2);
    chk("cont cleared", 1'b0, cont);
    run("dual full", OP_DUAL_DDR, 2, 0, 3, $urandom, 4, 4'h0, 2);
    d = 2 + $urandom % 6;
    cfg(0, 1, 4'h0, 4'h0, 4'(d));
    run("dual flag", OP_DUAL_DDR, 2, 0, 4, $urandom, d, 4'h0, 2);
    cfg(0, 0, 4'h0, 4'h0, 4'(d));
    run("dual4", OP_DUAL_DDR_4B, 2, 0, 4, $urandom, d, 4'h3, 2);
    // Each busy source against one read flavour
    for (int i = 0; i < 3; i++)
    begin
      cfg(i == 1, 0, 4'h0, 4'h0, 4'h0);
      busy <= 3'(1 << i);
      repeat (3) @(posedge clk);
      chk("busy flag set", 1'b1, busyFlag);
      rejN = 0;
      oeHit = 0;
      host.xfer(i == 2 ? OP_DUAL_DDR : OP_SINGLE_DDR, i == 0 ? 1 : 6 - 2 * i,
                i == 1, 0, 3, $urandom, 8, 4'h0, 0);
      chk("refusals", 1, rejN);
      chk("lines idle", 0, oeHit);
      busy <= 3'h0;
      repeat (3) @(posedge clk);
      chk("busy flag clear", 1'b0, busyFlag);
      $display("Test busy %0d done", i);
    end
    wrap_up();
  end
endmodule

bind fdrc_top fdrc_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.clk, .resetn,
  .chipEnableN, .ioOe, .quad_opcode_mode, .programActive, .eraseActive,
  .statusWriteActive, .write_in_progress, .continuous_read_mode,
  .readActive, .commandRejected, .memReqValid, .memReqReady, .memReqAddr);
